// ==== common/pxb_pkg.sv ====
// package: opcodes, field widths and reset values for the pack/extend/bitfield unit
`default_nettype none
package pxb_pkg;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned HALF_W   = 16;
   localparam int unsigned SHAMT_W  = 5;
   localparam int unsigned ROT_W    = 2;
   localparam int unsigned POS_W    = 5;
   localparam int unsigned WID_W    = 6;
   localparam int unsigned LATENCY  = 1;
   localparam logic [31:0] RESULT_RST = 32'h0000_0000;
   localparam logic [3:0]  FLAGS_RST  = 4'h0;

   typedef enum logic [4:0] {
      PXB_PACK_BOTTOM_TOP,
      PXB_PACK_TOP_BOTTOM,
      PXB_SIGN_EXTEND_BYTE,
      PXB_SIGN_EXTEND_HALF,
      PXB_DUAL_SIGN_EXTEND_BYTE,
      PXB_ZERO_EXTEND_BYTE,
      PXB_ZERO_EXTEND_HALF,
      PXB_DUAL_ZERO_EXTEND_BYTE,
      PXB_SIGN_EXTEND_BYTE_ADD,
      PXB_SIGN_EXTEND_HALF_ADD,
      PXB_DUAL_SIGN_EXTEND_BYTE_ADD,
      PXB_ZERO_EXTEND_BYTE_ADD,
      PXB_ZERO_EXTEND_HALF_ADD,
      PXB_DUAL_ZERO_EXTEND_BYTE_ADD,
      PXB_FIELD_CLEAR,
      PXB_FIELD_INSERT,
      PXB_SIGNED_FIELD_EXTRACT,
      PXB_UNSIGNED_FIELD_EXTRACT
   } pxb_op_t;
endpackage
`default_nettype wire

// ==== rtl/pxb_field_mask.sv ====
// field mask generator: ones from lsb for width bits, and a low mask of width bits from bit 0
`timescale 1ns/1ps
`default_nettype none
module pxb_field_mask
   import pxb_pkg::*;
(
   input  wire logic [pxb_pkg::POS_W-1:0]  lsb_i,
   input  wire logic [pxb_pkg::WID_W-1:0]  width_i,
   output logic      [pxb_pkg::DATA_W-1:0] mask_o,
   output logic      [pxb_pkg::DATA_W-1:0] low_mask_o
);
   import pxb_pkg::*;

   // per-bit compare; width 32 needs the sixth width bit
   genvar g;
   generate
      for (g = 0; g < DATA_W; g++)
      begin : g_bit
         assign low_mask_o[g] = (6'(g) < width_i);
         assign mask_o[g]     = (6'(g) >= {1'b0, lsb_i}) &&
                                ((6'(g) - {1'b0, lsb_i}) < width_i);
      end
   endgenerate
endmodule
`default_nettype wire

// ==== rtl/pxb_alu.sv ====
// pack, extend, extend-and-add and bitfield datapath, one cycle latency
// Function
// - pack top-bottom: first top, shifted second bottom
// - pack bottom-top: first bottom, shifted second top
// - top-bottom shift 1..32, zero means 32
// - pack operations leave flags unchanged
// - extends rotate source by 0/8/16/24 first
// - no rotation passes source unrotated
// - signed byte/half extend replicates top bit
// - unsigned byte/half extend fills zeros
// - dual signed byte extend into halves
// - dual unsigned byte extend into halves
// - extend-add adds word or each half
// - field clear zeroes selected destination bits
// - field insert copies low source bits
// - signed extract sign-extends selected field
// - unsigned extract zero-extends selected field
// - extend and bitfield ops keep flags
`timescale 1ns/1ps
`default_nettype none
module pxb_alu
   import pxb_pkg::*;
(
   input  wire logic                         CORE_CLK_I,
   input  wire logic                         RST_N_I,
   input  wire logic                         CLK_EN_I,
   input  wire logic                         ISSUE_I,
   input  wire pxb_pkg::pxb_op_t             OP_I,
   input  wire logic [pxb_pkg::DATA_W-1:0]   SRC_A_I,
   input  wire logic [pxb_pkg::DATA_W-1:0]   SRC_B_I,
   input  wire logic [pxb_pkg::DATA_W-1:0]   DEST_I,
   input  wire logic [pxb_pkg::SHAMT_W-1:0]  SHAMT_I,
   input  wire logic [pxb_pkg::ROT_W-1:0]    ROT_I,
   input  wire logic [pxb_pkg::POS_W-1:0]    LSB_I,
   input  wire logic [pxb_pkg::WID_W-1:0]    WIDTH_I,
   input  wire logic [3:0]                   FLAGS_I,
   output logic                              DONE_O,
   output logic      [pxb_pkg::DATA_W-1:0]   RESULT_O,
   output logic      [3:0]                   FLAGS_O
);
   import pxb_pkg::*;

   // ------------------------------------------------------------
   // pack shifter
   // ------------------------------------------------------------
   logic signed [DATA_W-1:0] b_signed;
   logic [DATA_W-1:0]        b_asr;
   logic [DATA_W-1:0]        b_lsl;
   assign b_signed = $signed(SRC_B_I);
   // zero field encodes a full 32 shift, same as 31 for the sign fill
   assign b_asr = (SHAMT_I == 5'h00) ? {DATA_W{SRC_B_I[DATA_W-1]}} :
                  DATA_W'(b_signed >>> SHAMT_I);
   assign b_lsl = SRC_B_I << SHAMT_I;

   // ------------------------------------------------------------
   // rotate and extend
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rot;
   logic [4:0]        rot_amt;
   assign rot_amt = {ROT_I, 3'h0};
   // rotation of zero leaves the word untouched
   assign rot = (SRC_B_I >> rot_amt) | (SRC_B_I << (6'd32 - {1'b0, rot_amt}));

   logic [DATA_W-1:0] ext_sb;
   logic [DATA_W-1:0] ext_sh;
   logic [DATA_W-1:0] ext_zb;
   logic [DATA_W-1:0] ext_zh;
   logic [DATA_W-1:0] ext_dsb;
   logic [DATA_W-1:0] ext_dzb;
   assign ext_sb  = {{24{rot[7]}}, rot[7:0]};
   assign ext_sh  = {{16{rot[15]}}, rot[15:0]};
   assign ext_zb  = {24'h00_0000, rot[7:0]};
   assign ext_zh  = {16'h0000, rot[15:0]};
   assign ext_dsb = {{8{rot[23]}}, rot[23:16], {8{rot[7]}}, rot[7:0]};
   assign ext_dzb = {8'h00, rot[23:16], 8'h00, rot[7:0]};

   // halves add separately so no carry crosses bit 16
   function automatic logic [DATA_W-1:0] dual_add(input logic [DATA_W-1:0] a,
                                                  input logic [DATA_W-1:0] b);
      dual_add = {16'(a[31:16] + b[31:16]), 16'(a[15:0] + b[15:0])};
   endfunction

   // ------------------------------------------------------------
   // bitfield
   // ------------------------------------------------------------
   logic [DATA_W-1:0] fmask;
   logic [DATA_W-1:0] lmask;
   pxb_field_mask u_mask (
      .lsb_i      (LSB_I),
      .width_i    (WIDTH_I),
      .mask_o     (fmask),
      .low_mask_o (lmask)
   );
   logic [DATA_W-1:0] fld_low;
   logic [DATA_W-1:0] fld_top;
   logic [DATA_W-1:0] sfx;
   logic [5:0]        top_pos;
   assign fld_low = (SRC_A_I >> LSB_I) & lmask;
   // top bit sits at width-1 after the shift; issuer keeps width >= 1
   assign top_pos = WIDTH_I - 6'd1;
   assign fld_top = fld_low >> top_pos[4:0];
   assign sfx     = fld_top[0] ? (fld_low | ~lmask) : fld_low;

   // span for the checks, built apart from the mask generator
   // so a fault in that generator cannot hide itself
   logic [DATA_W-1:0] chk_mask;
   assign chk_mask = (32'hffff_ffff >> (6'd32 - WIDTH_I)) << LSB_I;

   // ------------------------------------------------------------
   // result select
   // ------------------------------------------------------------
   logic [DATA_W-1:0] res_d;
   always_comb
   begin
      unique case (OP_I)
         PXB_PACK_BOTTOM_TOP:           res_d = {b_lsl[31:16], SRC_A_I[15:0]};
         PXB_PACK_TOP_BOTTOM:           res_d = {SRC_A_I[31:16], b_asr[15:0]};
         PXB_SIGN_EXTEND_BYTE:          res_d = ext_sb;
         PXB_SIGN_EXTEND_HALF:          res_d = ext_sh;
         PXB_DUAL_SIGN_EXTEND_BYTE:     res_d = ext_dsb;
         PXB_ZERO_EXTEND_BYTE:          res_d = ext_zb;
         PXB_ZERO_EXTEND_HALF:          res_d = ext_zh;
         PXB_DUAL_ZERO_EXTEND_BYTE:     res_d = ext_dzb;
         PXB_SIGN_EXTEND_BYTE_ADD:      res_d = SRC_A_I + ext_sb;
         PXB_SIGN_EXTEND_HALF_ADD:      res_d = SRC_A_I + ext_sh;
         PXB_DUAL_SIGN_EXTEND_BYTE_ADD: res_d = dual_add(SRC_A_I, ext_dsb);
         PXB_ZERO_EXTEND_BYTE_ADD:      res_d = SRC_A_I + ext_zb;
         PXB_ZERO_EXTEND_HALF_ADD:      res_d = SRC_A_I + ext_zh;
         PXB_DUAL_ZERO_EXTEND_BYTE_ADD: res_d = dual_add(SRC_A_I, ext_dzb);
         PXB_FIELD_CLEAR:               res_d = DEST_I & ~fmask;
         PXB_FIELD_INSERT:              res_d = (DEST_I & ~fmask) |
                                                ((SRC_A_I << LSB_I) & fmask);
         PXB_SIGNED_FIELD_EXTRACT:      res_d = sfx;
         PXB_UNSIGNED_FIELD_EXTRACT:    res_d = fld_low;
         default:                       res_d = RESULT_RST;
      endcase
   end

   // ------------------------------------------------------------
   // output registers
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         RESULT_O <= RESULT_RST;
      else if (CLK_EN_I && ISSUE_I)
         RESULT_O <= res_d;
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         DONE_O <= 1'b0;
      else if (CLK_EN_I)
         DONE_O <= ISSUE_I;
   end

   // flags pass through untouched by every operation here
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         FLAGS_O <= FLAGS_RST;
      else if (CLK_EN_I && ISSUE_I)
         FLAGS_O <= FLAGS_I;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_issue;
      CLK_EN_I && ISSUE_I;
   endsequence

   AST_FLAGS_KEPT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      s_issue |=> FLAGS_O == $past(FLAGS_I))
      else $error("flags changed by operation");
   AST_EXT_FLAGS: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      s_issue ##1 (CLK_EN_I && !ISSUE_I) |=> FLAGS_O == $past(FLAGS_I, 2))
      else $error("flags not held between operations");
   AST_PACK_TB: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_PACK_TOP_BOTTOM)) |=>
      RESULT_O[31:16] == $past(SRC_A_I[31:16]))
      else $error("pack top half wrong");
   AST_PACK_BT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_PACK_BOTTOM_TOP)) |=>
      RESULT_O[15:0] == $past(SRC_A_I[15:0]) &&
      {16'h0000, RESULT_O[31:16]} == (($past(SRC_B_I) << $past(SHAMT_I)) >> 16))
      else $error("pack bottom-top wrong");
   AST_ASR32: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_PACK_TOP_BOTTOM && SHAMT_I == 5'h00)) |=>
      RESULT_O[15:0] == {16{$past(SRC_B_I[31])}})
      else $error("zero shift field not 32");
   AST_NOROT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_ZERO_EXTEND_HALF && ROT_I == 2'h0)) |=>
      RESULT_O == {16'h0000, $past(SRC_B_I[15:0])})
      else $error("unrotated extend wrong");
   AST_SIGN_EXTEND_BYTE: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_SIGN_EXTEND_BYTE)) |=>
      RESULT_O[31:8] == {24{RESULT_O[7]}})
      else $error("sign fill wrong");
   AST_DZB: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_DUAL_ZERO_EXTEND_BYTE)) |=>
      RESULT_O[31:24] == 8'h00 && RESULT_O[15:8] == 8'h00)
      else $error("dual zero extend fill wrong");
   AST_CLEAR: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_FIELD_CLEAR)) |=>
      (RESULT_O & $past(chk_mask)) == 32'h0000_0000 &&
      (RESULT_O & ~$past(chk_mask)) == ($past(DEST_I) & ~$past(chk_mask)))
      else $error("field clear wrong");
   AST_INSERT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_FIELD_INSERT)) |=>
      (RESULT_O & ~$past(chk_mask)) == ($past(DEST_I) & ~$past(chk_mask)) &&
      ((RESULT_O >> $past(LSB_I)) & ~(32'hffff_ffff << $past(WIDTH_I))) ==
      ($past(SRC_A_I) & ~(32'hffff_ffff << $past(WIDTH_I))))
      else $error("field insert wrong");
   AST_UFX: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (s_issue and (OP_I == PXB_UNSIGNED_FIELD_EXTRACT)) |=>
      RESULT_O == (($past(SRC_A_I) & $past(chk_mask)) >> $past(LSB_I)))
      else $error("unsigned extract wrong");
   AST_DONE: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      s_issue |=> DONE_O)
      else $error("done missing");
   AST_DONE_LOW: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (CLK_EN_I && !ISSUE_I) |=> !DONE_O)
      else $error("done without request");
   // enable low must freeze every output, a pending request included
   AST_FROZEN: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      !CLK_EN_I |=> $stable(DONE_O) && $stable(RESULT_O) && $stable(FLAGS_O))
      else $error("outputs moved while enable low");
endmodule
`default_nettype wire

// ==== test/pxb_issuer_model.sv ====
// issuer model: decoder side that drives requests into the unit
`timescale 1ns/1ps
`default_nettype none
module pxb_issuer_model
   import pxb_pkg::*;
(
   input  wire logic            clk_i,
   output logic                 en_o,
   output logic                 issue_o,
   output var pxb_pkg::pxb_op_t op_o,
   output logic [31:0]          a_o,
   output logic [31:0]          b_o,
   output logic [31:0]          d_o,
   output logic [4:0]           sh_o,
   output logic [1:0]           rot_o,
   output logic [4:0]           lsb_o,
   output logic [5:0]           wid_o,
   output logic [3:0]           fl_o
);
   initial
   begin
      {en_o, issue_o, a_o, b_o, d_o, sh_o, rot_o, lsb_o, wid_o, fl_o} = '0;
      op_o = PXB_PACK_BOTTOM_TOP;
   end
   task automatic send(pxb_op_t op, logic [31:0] a, b, d, logic [4:0] sh, logic [1:0] rot,
                       logic [4:0] lsb, logic [5:0] wid, logic [3:0] fl);
      @(posedge clk_i);
      en_o <= 1'b1;
      issue_o <= 1'b1;
      op_o <= op;
      {a_o, b_o, d_o} <= {a, b, d};
      {sh_o, rot_o, lsb_o, wid_o, fl_o} <= {sh, rot, lsb, wid, fl};
   endtask
   // stale operands are inverted so a leftover value is never read as valid
   task automatic hold(logic en, logic iss);
      @(posedge clk_i);
      en_o <= en;
      issue_o <= iss;
      {a_o, b_o, d_o} <= ~{a_o, b_o, d_o};
   endtask
endmodule
`default_nettype wire

// ==== test/pack_extend_bitfield_alu_tb.sv ====
// self-checking bench for the pack/extend/bitfield unit
`timescale 1ns/1ps
`default_nettype none
module pack_extend_bitfield_alu_tb;
   import pxb_pkg::*;
   logic        clk, rst_n, en, iss, done;
   pxb_op_t     op;
   logic [31:0] a, b, d, res, last_res;
   logic [4:0]  sh, lsb;
   logic [1:0]  rot;
   logic [5:0]  wid;
   logic [3:0]  fl, flo;
   logic [35:0] exp_q[$];
   logic [35:0] e;
   int          fails, checks, seed, n, i, r;
   logic [4:0]  shv[4] = '{5'd0, 5'd1, 5'd31, 5'd16};
   logic [4:0]  lsbv[4] = '{5'd0, 5'd31, 5'd8, 5'd20};
   logic [5:0]  widv[4] = '{6'd32, 6'd1, 6'd12, 6'd4};
   pxb_issuer_model u_iss (.clk_i(clk), .en_o(en), .issue_o(iss), .op_o(op), .a_o(a), .b_o(b),
      .d_o(d), .sh_o(sh), .rot_o(rot), .lsb_o(lsb), .wid_o(wid), .fl_o(fl));
   pxb_alu DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(en), .ISSUE_I(iss), .OP_I(op),
      .SRC_A_I(a), .SRC_B_I(b), .DEST_I(d), .SHAMT_I(sh), .ROT_I(rot), .LSB_I(lsb),
      .WIDTH_I(wid), .FLAGS_I(fl), .DONE_O(done), .RESULT_O(res), .FLAGS_O(flo));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] model(pxb_op_t o, logic [31:0] a, b, d, logic [4:0] sh,
                                         logic [1:0] rot, logic [4:0] lsb, logic [5:0] wid);
      logic [63:0]        w;
      logic [31:0]        x, p, m, sb, sx, zb, zh, ds, dz;
      logic signed [31:0] q;
      w = {b, b} >> (rot * 8);
      x = w[31:0];
      p = b << sh;
      q = $signed(b) >>> ((sh == 0) ? 32 : sh);
      sb = {{24{x[7]}}, x[7:0]};
      sx = {{16{x[15]}}, x[15:0]};
      zb = {24'h0, x[7:0]};
      zh = {16'h0, x[15:0]};
      ds = {{8{x[23]}}, x[23:16], {8{x[7]}}, x[7:0]};
      dz = {8'h0, x[23:16], 8'h0, x[7:0]};
      w = ((64'h1 << wid) - 64'h1) << lsb;
      m = w[31:0];
      case (o)
         PXB_PACK_BOTTOM_TOP: return {p[31:16], a[15:0]};
         PXB_PACK_TOP_BOTTOM: return {a[31:16], q[15:0]};
         PXB_SIGN_EXTEND_BYTE: return sb;
         PXB_SIGN_EXTEND_HALF: return sx;
         PXB_DUAL_SIGN_EXTEND_BYTE: return ds;
         PXB_ZERO_EXTEND_BYTE: return zb;
         PXB_ZERO_EXTEND_HALF: return zh;
         PXB_DUAL_ZERO_EXTEND_BYTE: return dz;
         PXB_SIGN_EXTEND_BYTE_ADD: return a + sb;
         PXB_SIGN_EXTEND_HALF_ADD: return a + sx;
         PXB_DUAL_SIGN_EXTEND_BYTE_ADD: return {a[31:16] + ds[31:16], a[15:0] + ds[15:0]};
         PXB_ZERO_EXTEND_BYTE_ADD: return a + zb;
         PXB_ZERO_EXTEND_HALF_ADD: return a + zh;
         PXB_DUAL_ZERO_EXTEND_BYTE_ADD: return {a[31:16] + dz[31:16], a[15:0] + dz[15:0]};
         PXB_FIELD_CLEAR: return d & ~m;
         PXB_FIELD_INSERT: return (d & ~m) | ((a << lsb) & m);
         PXB_SIGNED_FIELD_EXTRACT: return $signed(a << (32 - lsb - wid)) >>> (32 - wid);
         default: return (a >> lsb) & ~(32'hffff_ffff << wid);
      endcase
   endfunction
   task automatic err(string s);
      fails++;
      $display("[ERR] %0t %s", $time, s);
   endtask
   task automatic cmp_res(logic [31:0] g, logic [31:0] x);
      checks++;
      if (g !== x) err($sformatf("result %h, expected %h", g, x));
   endtask
   task automatic cmp_flags(logic [3:0] g, logic [3:0] x);
      checks++;
      if (g !== x) err($sformatf("flags %h, expected %h", g, x));
   endtask
   task automatic cmp_bit(logic g, logic x);
      checks++;
      if (g !== x) err("done level wrong");
   endtask
   task automatic go(pxb_op_t o, logic [31:0] a, b, d, logic [4:0] sh, logic [1:0] rot,
                     logic [4:0] lsb, logic [5:0] wid);
      logic [3:0] f;
      f = $random(seed);
      if (wid == 0 || wid > 32 - lsb) wid = 6'd32 - lsb;
      exp_q.push_back({model(o, a, b, d, sh, rot, lsb, wid), f});
      u_iss.send(o, a, b, d, sh, rot, lsb, wid, f);
   endtask
   task automatic test_done();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      #1;
      if (done === 1'b1)
      begin
         if (exp_q.size() == 0)
            err("result without request");
         else
         begin
            e = exp_q.pop_front();
            last_res = e[35:4];
            cmp_res(res, e[35:4]);
            cmp_flags(flo, e[3:0]);
         end
      end
   end
   initial
   begin
      seed = 32'h49078014;
      rst_n = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 18; i++)
         for (r = 0; r < 4; r++)
            go(pxb_op_t'(i), $random(seed), $random(seed), $random(seed), $random(seed), r,
               $random(seed), $random(seed));
      for (i = 0; i < 4; i++)
      begin
         go(PXB_PACK_TOP_BOTTOM, $random(seed), 32'h8001_7ffe ^ i, 0, shv[i], 0, 0, 1);
         go(PXB_PACK_BOTTOM_TOP, $random(seed), 32'h0001_ffff ^ i, 0, shv[i], 0, 0, 1);
         for (r = 14; r < 18; r++)
            go(pxb_op_t'(r), $random(seed), $random(seed), $random(seed), 0, 0, lsbv[i],
               widv[i]);
      end
      // enable low must freeze outputs and swallow the request
      repeat (2) u_iss.hold(1'b1, 1'b0);
      repeat (3) u_iss.hold(1'b0, 1'b1);
      @(negedge clk);
      cmp_bit(done, 1'b0);
      cmp_res(res, last_res);
      u_iss.hold(1'b1, 1'b0);
      go(PXB_ZERO_EXTEND_BYTE, $random(seed), $random(seed), 0, 0, 1, 0, 1);
      u_iss.hold(1'b1, 1'b0);
      @(posedge clk);
      rst_n <= 1'b0;
      #2;
      cmp_bit(done, 1'b0);
      cmp_res(res, RESULT_RST);
      cmp_flags(flo, FLAGS_RST);
      @(posedge clk);
      rst_n <= 1'b1;
      for (n = 0; n < 300; n++)
      begin
         if ($random(seed) & 1) u_iss.hold(1'b1, 1'b0);
         go(pxb_op_t'(n % 18), $random(seed), $random(seed), $random(seed), $random(seed),
            $random(seed), $random(seed), $random(seed));
      end
      u_iss.hold(1'b1, 1'b0);
      for (n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge clk);
      if (exp_q.size() != 0) err("results missing");
      test_done();
   end
endmodule
`default_nettype wire
